// ==== hdl/pmc_pkg.sv ====
// package: constants and types for the power mode controller
package pmc_pkg;

    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] PMC_ADR_PWR_CTRL = 4'h0;
    localparam logic [3:0] PMC_ADR_WAKE_CFG = 4'h4;
    localparam logic [3:0] PMC_ADR_FLSCALE  = 4'h8;
    localparam logic [3:0] PMC_ADR_STATUS   = 4'hC;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PMC_PC_IDLE      = 0;
    localparam int PMC_PC_STOP      = 1;
    localparam int PMC_WC_RTC_FAIL  = 0;
    localparam int PMC_WC_RTC_ALARM = 1;
    localparam int PMC_WC_PORT      = 2;
    localparam int PMC_WC_CMP0      = 3;
    localparam int PMC_WC_RSTPIN    = 4;
    localparam int PMC_WC_SUSPEND   = 6;
    localparam int PMC_WC_SLEEP     = 7;
    localparam int PMC_FS_BYPASS    = 6;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  PMC_RST_BYTE   = 8'h00;
    localparam logic [15:0] PMC_RESET_VEC  = 16'h0000;
    localparam int          PMC_NUM_MODES  = 5;
    localparam int          PMC_FLAG_HIDE  = 2;
    localparam logic [1:0]  PMC_HIDE_LOAD  = 2'h2;
    localparam int          PMC_NUM_WAKE   = 5;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PMC_NORMAL, PMC_IDLE, PMC_STOP, PMC_SUSPEND, PMC_SLEEP
    } pmc_mode_type;

    typedef struct packed {
        logic rtc_fail;
        logic rtc_alarm;
        logic port_match;
        logic cmp0_rise;
    } pmc_wake_type;

    typedef struct packed {
        pmc_mode_type mode;
        logic [1:0]   pwr_ctrl;
        logic [4:0]   wake_en;
        logic [4:0]   wake_flag;
        logic         bypass;
        logic [1:0]   hide_cnt;
        logic         ack;
        logic [31:0]  dat;
        logic         rst_pin_s1;
        logic         rst_pin_s2;
        logic         rst_pin_d;
        logic         core_rst;
        logic         resume;
    } pmc_state_type;

endpackage : pmc_pkg

// ==== hdl/pmc_power_mode_controller.sv ====
// power mode controller: mode sequencing, wake-up and reset requests
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module pmc_power_mode_controller (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // chip-side events
    input  wire logic                  instr_done,
    input  wire logic                  irq_pending,
    input  wire logic                  ext_rst,
    input  wire logic                  watchdog_timer_expired,
    input  wire logic                  mcd_timeout,
    input  wire logic                  two_cell_mode,
    input  wire pmc_pkg::pmc_wake_type wake_evt,
    input  wire logic                  rst_pin_n,
    // controls towards the chip
    output pmc_pkg::pmc_mode_type      mode,
    output logic                       cpu_halt,
    output logic                       precise_osc_en,
    output logic                       int_osc_en,
    output logic                       sysclk_gate_n,
    output logic                       core_regulator_en,
    output logic                       resume_next,
    output logic                       core_reset_req,
    output logic [15:0]                reset_vector,
    output logic                       flash_bypass
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pmc_pkg::pmc_state_type s_r;
    pmc_pkg::pmc_state_type s_nxt;

    logic       wr_stb;
    logic       rd_stb;
    logic [4:0] evt_vec;
    logic       pin_fall;
    logic       any_wake;
    logic [7:0] wcfg_rd;

    // a write lands at the edge that sees ack high
    assign wr_stb   = wb_cyc_i && wb_stb_i && s_r.ack && wb_we_i
                      && wb_sel_i[0];
    assign rd_stb   = wb_cyc_i && wb_stb_i && !s_r.ack && !wb_we_i;
    assign pin_fall = s_r.rst_pin_d && !s_r.rst_pin_s2;
    assign evt_vec  = {pin_fall, wake_evt.cmp0_rise && two_cell_mode,
                       wake_evt.port_match, wake_evt.rtc_alarm,
                       wake_evt.rtc_fail};
    // reset pin wake is never masked
    assign any_wake = |(evt_vec[3:0] & s_r.wake_en[3:0]) || pin_fall;
    // flags hidden for two clocks after wake
    assign wcfg_rd  = (s_r.hide_cnt != 2'h0) ? 8'h00 :
                      {s_r.mode == pmc_pkg::PMC_SLEEP,
                       s_r.mode == pmc_pkg::PMC_SUSPEND, 1'b0,
                       s_r.wake_flag};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.rst_pin_s1 = rst_pin_n;
        s_nxt.rst_pin_s2 = s_r.rst_pin_s1;
        s_nxt.rst_pin_d  = s_r.rst_pin_s2;
        s_nxt.core_rst   = 1'b0;
        s_nxt.resume     = 1'b0;
        s_nxt.ack        = wb_cyc_i && wb_stb_i && !s_r.ack;
        if (s_r.hide_cnt != 2'h0) begin
            s_nxt.hide_cnt = s_r.hide_cnt - 2'h1;
        end
        // flags follow events in every mode
        s_nxt.wake_flag = s_r.wake_flag | evt_vec;
        if (rd_stb) begin
            unique case (wb_adr_i)
                pmc_pkg::PMC_ADR_PWR_CTRL: s_nxt.dat = {30'h0, s_r.pwr_ctrl};
                pmc_pkg::PMC_ADR_WAKE_CFG: s_nxt.dat = {24'h0, wcfg_rd};
                pmc_pkg::PMC_ADR_FLSCALE:  s_nxt.dat = {25'h0, s_r.bypass,
                                                        6'h00};
                pmc_pkg::PMC_ADR_STATUS:   s_nxt.dat = {29'h0, s_r.mode};
                default:                   s_nxt.dat = 32'h0000_0000;
            endcase
        end
        if (wr_stb) begin
            unique case (wb_adr_i)
                pmc_pkg::PMC_ADR_PWR_CTRL: begin
                    s_nxt.pwr_ctrl = wb_dat_i[1:0];
                end
                pmc_pkg::PMC_ADR_WAKE_CFG: begin
                    // enables come only from this write
                    s_nxt.wake_en = wb_dat_i[4:0];
                    // a halted core cannot select a mode; stop stays put
                    if (s_r.mode == pmc_pkg::PMC_NORMAL) begin
                        if (wb_dat_i[pmc_pkg::PMC_WC_SLEEP]) begin
                            s_nxt.mode = pmc_pkg::PMC_SLEEP;
                        end else if (wb_dat_i[pmc_pkg::PMC_WC_SUSPEND]) begin
                            s_nxt.mode = pmc_pkg::PMC_SUSPEND;
                        end
                    end
                    // a write of a zero clears a flag, new events win
                    s_nxt.wake_flag = (s_r.wake_flag & wb_dat_i[4:0])
                                      | evt_vec;
                end
                pmc_pkg::PMC_ADR_FLSCALE: begin
                    s_nxt.bypass = wb_dat_i[pmc_pkg::PMC_FS_BYPASS];
                end
                default: begin
                end
            endcase
        end
        unique case (s_r.mode)
            pmc_pkg::PMC_NORMAL: begin
                // entry waits for the writing instruction to finish
                if (instr_done && s_r.pwr_ctrl[pmc_pkg::PMC_PC_STOP]) begin
                    s_nxt.mode = pmc_pkg::PMC_STOP;
                end else if (instr_done
                             && s_r.pwr_ctrl[pmc_pkg::PMC_PC_IDLE]) begin
                    s_nxt.mode = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (ext_rst || watchdog_timer_expired) begin
                    s_nxt.core_rst = 1'b1;
                    s_nxt.mode     = pmc_pkg::PMC_NORMAL;
                    s_nxt.pwr_ctrl = 2'h0;
                end else if (irq_pending) begin
                    s_nxt.pwr_ctrl[pmc_pkg::PMC_PC_IDLE] = 1'b0;
                    s_nxt.resume   = 1'b1;
                    s_nxt.mode     = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_STOP: begin
                // nothing but a reset leaves stop
                if (ext_rst || mcd_timeout || watchdog_timer_expired) begin
                    s_nxt.core_rst = 1'b1;
                    s_nxt.mode     = pmc_pkg::PMC_NORMAL;
                    s_nxt.pwr_ctrl = 2'h0;
                end
            end
            pmc_pkg::PMC_SUSPEND,
            pmc_pkg::PMC_SLEEP: begin
                if (any_wake) begin
                    s_nxt.mode     = pmc_pkg::PMC_NORMAL;
                    s_nxt.resume   = 1'b1;
                    s_nxt.wake_en  = 5'h00;
                    s_nxt.hide_cnt = pmc_pkg::PMC_HIDE_LOAD;
                end
            end
            default: begin
                s_nxt.mode = pmc_pkg::PMC_NORMAL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r            <= '0;
            s_r.mode       <= pmc_pkg::PMC_NORMAL;
            s_r.rst_pin_s1 <= 1'b1;
            s_r.rst_pin_s2 <= 1'b1;
            s_r.rst_pin_d  <= 1'b1;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mode              = s_r.mode;
    // only normal runs code
    assign cpu_halt          = s_r.mode != pmc_pkg::PMC_NORMAL;
    // idle leaves clocks and peripherals running
    assign precise_osc_en    = s_r.mode == pmc_pkg::PMC_NORMAL
                               || s_r.mode == pmc_pkg::PMC_IDLE;
    assign int_osc_en        = s_r.mode != pmc_pkg::PMC_SUSPEND
                               && s_r.mode != pmc_pkg::PMC_SLEEP;
    assign sysclk_gate_n     = int_osc_en;
    assign core_regulator_en = s_r.mode != pmc_pkg::PMC_SLEEP;
    assign resume_next       = s_r.resume;
    assign core_reset_req    = s_r.core_rst;
    assign reset_vector      = pmc_pkg::PMC_RESET_VEC;
    assign flash_bypass      = s_r.bypass;
    assign wb_ack_o          = s_r.ack;
    assign wb_dat_o          = s_r.dat;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------
    a_ack_one_pulse: assert property (clk_en && wb_ack_o
        |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    a_ack_needs_req: assert property (clk_en && !(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o)
        else $error("ack without request");

    // ------------------------------------------------------------
    // entry and exit checks
    // ------------------------------------------------------------
    a_normal_runs: assert property (s_r.mode == pmc_pkg::PMC_NORMAL
        |-> !cpu_halt && precise_osc_en && sysclk_gate_n)
        else $error("normal mode not running");

    a_idle_entry: assert property (clk_en && s_r.mode == pmc_pkg::PMC_NORMAL
        && instr_done && s_r.pwr_ctrl == 2'h1 |=> cpu_halt)
        else $error("idle not entered");

    a_stop_entry: assert property (clk_en && s_r.mode == pmc_pkg::PMC_NORMAL
        && instr_done && s_r.pwr_ctrl[1] |=> !precise_osc_en)
        else $error("stop not entered");

    a_idle_osc_on: assert property (s_r.mode == pmc_pkg::PMC_IDLE
        |-> precise_osc_en && int_osc_en && core_regulator_en)
        else $error("idle stopped clocks");

    a_idle_rst_exit: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_IDLE && ext_rst |=> core_reset_req && !cpu_halt)
        else $error("reset did not end idle");

    a_stop_hold: assert property (clk_en && s_r.mode == pmc_pkg::PMC_STOP
        && !ext_rst && !mcd_timeout && !watchdog_timer_expired
        |=> s_r.mode == pmc_pkg::PMC_STOP)
        else $error("stop left without reset");

    a_resume_pulse: assert property (clk_en && resume_next
        |=> !resume_next)
        else $error("resume longer than one cycle");

    // ------------------------------------------------------------
    // suspend and sleep checks
    // ------------------------------------------------------------
    a_susp_gated: assert property (s_r.mode == pmc_pkg::PMC_SUSPEND
        |-> !sysclk_gate_n && !int_osc_en && cpu_halt)
        else $error("suspend clock not gated");

    a_wake_en_clear: assert property (clk_en && (s_r.mode ==
        pmc_pkg::PMC_SUSPEND || s_r.mode == pmc_pkg::PMC_SLEEP)
        && any_wake |=> s_r.wake_en == 5'h00)
        else $error("wake enables kept");

    a_sleep_wake_resume: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_SLEEP && any_wake |=> resume_next && !cpu_halt)
        else $error("sleep wake did not resume");

    a_cmp_one_cell: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_SLEEP && !two_cell_mode && !pin_fall
        && (evt_vec[2:0] & s_r.wake_en[2:0]) == 3'h0
        |=> s_r.mode == pmc_pkg::PMC_SLEEP)
        else $error("comparator woke in one-cell mode");

    a_pin_flag: assert property (clk_en && pin_fall
        |=> s_r.wake_flag[4])
        else $error("pin flag missed");

    a_flag_hide_late: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_SUSPEND && any_wake ##1 clk_en |=> wcfg_rd == 8'h00)
        else $error("flags visible in second clock");

    // ------------------------------------------------------------
    // mode checks
    // ------------------------------------------------------------

    a_stop_exit_reset: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_STOP ##1 s_r.mode != pmc_pkg::PMC_STOP
        |-> core_reset_req)
        else $error("stop left without reset");
    a_idle_irq_wake: assert property (clk_en && s_r.mode == pmc_pkg::PMC_IDLE
        && irq_pending && !ext_rst && !watchdog_timer_expired
        |=> resume_next && !s_r.pwr_ctrl[0] && !cpu_halt)
        else $error("idle not ended by interrupt");
    a_idle_wdt_reset: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_IDLE && watchdog_timer_expired |=> core_reset_req)
        else $error("watchdog did not end idle");
    a_stop_mcd_reset: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_STOP && mcd_timeout |=> core_reset_req)
        else $error("clock detector did not end stop");
    a_flag_hide_two: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_SUSPEND && any_wake |=> wcfg_rd == 8'h00)
        else $error("flags visible after wake");
    a_pin_wakes_sleep: assert property (clk_en && s_r.mode ==
        pmc_pkg::PMC_SLEEP && pin_fall |=> s_r.mode == pmc_pkg::PMC_NORMAL)
        else $error("reset pin did not wake");
    a_flag_sticks: assert property (clk_en && evt_vec[2]
        |=> s_r.wake_flag[2])
        else $error("wake flag missed");
    a_sleep_supply: assert property (s_r.mode == pmc_pkg::PMC_SLEEP
        |-> !core_regulator_en && !int_osc_en)
        else $error("sleep supply still on");
    a_stop_osc_off: assert property (s_r.mode == pmc_pkg::PMC_STOP
        |-> cpu_halt && !precise_osc_en && int_osc_en)
        else $error("stop clocks wrong");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_suspend_wake: cover property (s_r.mode == pmc_pkg::PMC_SUSPEND ##1
        s_r.mode == pmc_pkg::PMC_NORMAL);
    c_stop_entry: cover property (s_r.mode == pmc_pkg::PMC_NORMAL ##1
        s_r.mode == pmc_pkg::PMC_STOP);
    c_idle_wake: cover property (s_r.mode == pmc_pkg::PMC_IDLE ##1
        resume_next);
    c_stop_reset: cover property (s_r.mode == pmc_pkg::PMC_STOP ##1
        core_reset_req);
    c_sleep_wake: cover property (s_r.mode == pmc_pkg::PMC_SLEEP ##1
        s_r.mode == pmc_pkg::PMC_NORMAL);

endmodule // pmc_power_mode_controller

`default_nettype wire

// ==== dv/pmc_power_mode_controller_tb.sv ====
// testbench: self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none

module pmc_power_mode_controller_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                  core_clk, rst_n, clk_en;
    logic                  wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]            wb_adr_i, wb_sel_i;
    logic [31:0]           wb_dat_i, wb_dat_o, rd, seed;
    logic                  instr_done, irq_pending, ext_rst;
    logic                  watchdog_timer_expired, mcd_timeout;
    logic                  two_cell_mode, rst_pin_n;
    pmc_pkg::pmc_wake_type wake_evt;
    pmc_pkg::pmc_mode_type mode;
    logic                  cpu_halt, precise_osc_en, int_osc_en;
    logic                  sysclk_gate_n, core_regulator_en;
    logic                  resume_next, core_reset_req, flash_bypass;
    logic [15:0]           reset_vector;
    int                    n_mismatch = 0, checks = 0, n_res = 0;
    int                    n_rst = 0, k;

    pmc_power_mode_controller dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .instr_done(instr_done), .irq_pending(irq_pending),
        .ext_rst(ext_rst), .watchdog_timer_expired(watchdog_timer_expired),
        .mcd_timeout(mcd_timeout), .two_cell_mode(two_cell_mode),
        .wake_evt(wake_evt), .rst_pin_n(rst_pin_n), .mode(mode),
        .cpu_halt(cpu_halt), .precise_osc_en(precise_osc_en),
        .int_osc_en(int_osc_en), .sysclk_gate_n(sysclk_gate_n),
        .core_regulator_en(core_regulator_en), .resume_next(resume_next),
        .core_reset_req(core_reset_req), .reset_vector(reset_vector),
        .flash_bypass(flash_bypass)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) chk("wb_ack_o", 32'h1, 32'h0);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                         input string nm);
        wb(1'b0, a, 4'hF, 32'h0);
        chk(nm, e, rd);
    endtask

    // c: instr_done, irq, ext_rst, watchdog, missing clock
    task automatic pulse(input logic [4:0] c,
                         input pmc_pkg::pmc_wake_type ev);
        {instr_done, irq_pending, ext_rst} <= c[4:2];
        {watchdog_timer_expired, mcd_timeout} <= c[1:0];
        wake_evt <= ev;
        @(posedge core_clk);
        {instr_done, irq_pending, ext_rst} <= 3'h0;
        {watchdog_timer_expired, mcd_timeout} <= 2'h0;
        wake_evt <= 4'h0;
        @(posedge core_clk);
    endtask

    task automatic wait_mode(input pmc_pkg::pmc_mode_type m);
        int n = 0;
        while (mode !== m && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        chk("mode", {29'h0, m}, {29'h0, mode});
    endtask

    task automatic end_of_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, monitors, watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (resume_next === 1'b1) n_res++;
        if (core_reset_req === 1'b1) n_rst++;
    end

    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
        {instr_done, irq_pending, ext_rst, mcd_timeout} = 4'h0;
        {watchdog_timer_expired, two_cell_mode, wake_evt} = 6'h0;
        {clk_en, rst_pin_n} = 2'h3;
        seed = 32'h0001_6EDF;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        wait_mode(pmc_pkg::PMC_NORMAL);
        chk("osc", 32'hF, {28'h0, precise_osc_en, int_osc_en,
            sysclk_gate_n, core_regulator_en});
        for (int i = 0; i < 4; i++) rdchk(4'(i * 4), 32'h0, "reg_rst");
        rdchk(4'h2, 32'h0, "unmapped");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wb(1'b1, pmc_pkg::PMC_ADR_FLSCALE, 4'hF, seed);
            rdchk(pmc_pkg::PMC_ADR_FLSCALE, seed & 32'h0000_0040, "fs");
            chk("flash_bypass", {31'h0, seed[6]}, {31'h0, flash_bypass});
        end
        wb(1'b1, pmc_pkg::PMC_ADR_FLSCALE, 4'hE, ~seed);
        rdchk(pmc_pkg::PMC_ADR_FLSCALE, seed & 32'h0000_0040, "fs_sel");
        wb(1'b1, pmc_pkg::PMC_ADR_FLSCALE, 4'hF, 32'h0);
        chk("bypass_off", 32'h0, {31'h0, flash_bypass});
        // idle, then interrupt wake
        wb(1'b1, pmc_pkg::PMC_ADR_PWR_CTRL, 4'hF, 32'h1);
        wait_mode(pmc_pkg::PMC_NORMAL);
        pulse(5'h10, 4'h0);
        wait_mode(pmc_pkg::PMC_IDLE);
        chk("idle_outs", 32'h3, {30'h0, cpu_halt, precise_osc_en});
        repeat (4) @(posedge core_clk);
        chk("idle_hold", {29'h0, pmc_pkg::PMC_IDLE}, {29'h0, mode});
        pulse(5'h08, 4'h0);
        wait_mode(pmc_pkg::PMC_NORMAL);
        rdchk(pmc_pkg::PMC_ADR_PWR_CTRL, 32'h0, "pwr_ctrl");
        chk("resume_cnt", 32'h1, 32'(n_res));
        // idle, watchdog reset
        wb(1'b1, pmc_pkg::PMC_ADR_PWR_CTRL, 4'hF, 32'h1);
        pulse(5'h10, 4'h0);
        pulse(5'h02, 4'h0);
        wait_mode(pmc_pkg::PMC_NORMAL);
        chk("reset_vector", 32'h0, {16'h0, reset_vector});
        // stop: interrupt ignored, missing clock and reset end it
        wb(1'b1, pmc_pkg::PMC_ADR_PWR_CTRL, 4'hF, 32'h2);
        pulse(5'h10, 4'h0);
        wait_mode(pmc_pkg::PMC_STOP);
        chk("stop_outs", 32'h5, {29'h0, cpu_halt, precise_osc_en,
            int_osc_en});
        pulse(5'h08, 4'h0);
        chk("mode", {29'h0, pmc_pkg::PMC_STOP}, {29'h0, mode});
        pulse(5'h01, 4'h0);
        wait_mode(pmc_pkg::PMC_NORMAL);
        rdchk(pmc_pkg::PMC_ADR_PWR_CTRL, 32'h0, "pwr_ctrl");
        wb(1'b1, pmc_pkg::PMC_ADR_PWR_CTRL, 4'hF, 32'h2);
        pulse(5'h10, 4'h0);
        pulse(5'h04, 4'h0);
        wait_mode(pmc_pkg::PMC_NORMAL);
        @(posedge core_clk);
        chk("reset_cnt", 32'h3, 32'(n_rst));
        wb(1'b1, pmc_pkg::PMC_ADR_PWR_CTRL, 4'hF, 32'h1);
        pulse(5'h10, 4'h0);
        pulse(5'h04, 4'h0);
        @(posedge core_clk);
        chk("idle_rst", 32'h4, 32'(n_rst));
        // suspend with a random wake source
        seed = lfsr(seed);
        k = int'(seed % 3);
        wb(1'b1, pmc_pkg::PMC_ADR_WAKE_CFG, 4'hF, 32'h40 | (32'h1 << k));
        wait_mode(pmc_pkg::PMC_SUSPEND);
        chk("gates", 32'h0, {30'h0, int_osc_en, sysclk_gate_n});
        rdchk(pmc_pkg::PMC_ADR_STATUS, 32'h3, "status");
        pulse(5'h00, 4'h2);
        if (k != 2) wait_mode(pmc_pkg::PMC_SUSPEND);
        pulse(5'h00, 4'(4'h8 >> k));
        wait_mode(pmc_pkg::PMC_NORMAL);
        repeat (2) @(posedge core_clk);
        rdchk(pmc_pkg::PMC_ADR_WAKE_CFG, (32'h1 << k) | 32'h4, "flags");
        wb(1'b1, pmc_pkg::PMC_ADR_WAKE_CFG, 4'hF, 32'h0);
        pulse(5'h00, 4'h2);
        rdchk(pmc_pkg::PMC_ADR_WAKE_CFG, 32'h4, "flags_later");
        // sleep: comparator ignored in one-cell mode, pin fall wakes
        wb(1'b1, pmc_pkg::PMC_ADR_WAKE_CFG, 4'hF, 32'h0000_0088);
        wait_mode(pmc_pkg::PMC_SLEEP);
        chk("sleep_outs", 32'h0, {30'h0, int_osc_en,
            core_regulator_en});
        pulse(5'h00, 4'h1);
        wait_mode(pmc_pkg::PMC_SLEEP);
        rst_pin_n <= 1'b0;
        wait_mode(pmc_pkg::PMC_NORMAL);
        rst_pin_n <= 1'b1;
        rdchk(pmc_pkg::PMC_ADR_WAKE_CFG, 32'h0, "flags_hidden");
        wb(1'b0, pmc_pkg::PMC_ADR_WAKE_CFG, 4'hF, 32'h0);
        chk("pin_flag", 32'h10, rd & 32'h10);
        chk("resume_cnt", 32'h3, 32'(n_res));
        end_of_test();
    end
endmodule // pmc_power_mode_controller_tb

`default_nettype wire
